// ---- pss_pkg.sv ----
// shared constants and types of the pipelined burst sram core
// assumes one 50 MHz clock and a synchronous active-low reset
`default_nettype none

package pss_pkg;

   // ==========================================================
   // array shape
   localparam int PSS_LANE_BITS   = 8;
   localparam int PSS_LANE_W      = 9;
   localparam int PSS_DEF_LANES   = 4;
   localparam int PSS_DEF_ADDR_W  = 21;

   // ==========================================================
   // burst and timing
   localparam int         PSS_BEAT_W     = 2;
   localparam logic [1:0] PSS_BEAT_FIRST = 2'h0;
   localparam logic [1:0] PSS_BEAT_STEP  = 2'h1;
   localparam int         PSS_RD_LAT     = 2;
   localparam int         PSS_CLK_NS     = 20;

   // ==========================================================
   // write queue
   localparam int PSS_FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      PSS_OP_IDLE,
      PSS_OP_READ,
      PSS_OP_WRITE
   } pss_op_e;

endpackage

`default_nettype wire

// ---- pss_fifo.sv ----
// first-in first-out queue with valid and ready on both sides
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module pss_fifo
#(
   parameter int W     = 8,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   // filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   localparam int PW = $clog2(DEPTH);

   initial
   begin
      if (DEPTH < 2 || (1 << PW) != DEPTH)
         $error("pss_fifo depth must be a power of two, at least 2");
   end

   logic [W-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0]   count_r;
   logic          push;
   logic          pop;

   assign in_ready  = (count_r != (PW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = store[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge sys_clk)
   begin
      if (push)
         store[wr_ptr_r] <= in_data;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= rd_ptr_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end

endmodule // pss_fifo

`default_nettype wire

// ---- pss_sram.sv ----
// pipelined burst sram core: registered command, two-stage read, queued
// self-timed writes. assumes the controller keeps to the bus timing and
// that all pins are synchronous to sys_clk except output_enable_n.
//
// Notes on behaviour
// - address, control, lane selects and write data are caught in registers on the rising edge.
// - read data leaves through output registers, so it changes only at clock edges.
// - while cycle_qualify_n is high every pipeline register holds its value.
// - a write burst starts only with the write strobe, and only lanes whose select is low change.
// - writes finish on their own from a queue, with no extra strobe or cycle.
// - on a load the part is selected only with all three chip selects active, else the cycle is a deselect.
// - the data drivers float during the data phase of a write unless the enabled cycle just before it was a read.
// - a new read or write is taken every enabled cycle in any order with no turnaround.
// - burst addresses follow linear or interleaved order as burst_linear picks.
// - the array is 2M x 36 with four lanes, 4M x 18 with two, or 1M x 72 with eight.
// - output_enable_n gates the drivers without the clock, on top of the internal control.
// - each lane select covers one data byte and that lane's parity bit, lane 0 upward.
`timescale 1ns/100ps
`default_nettype none

module pss_sram
   import pss_pkg::*;
#(
   parameter int ADDR_W = PSS_DEF_ADDR_W,
   parameter int LANES  = PSS_DEF_LANES
)
(
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       resetn,
   // command
   input  wire logic                       cycle_qualify_n,
   input  wire logic [ADDR_W-1:0]          addr,
   input  wire logic                       write_enable_n,
   input  wire logic                       burst_advance_or_load,
   input  wire logic [LANES-1:0]           lane_write_select_n,
   input  wire logic                       select_first_n,
   input  wire logic                       select_second,
   input  wire logic                       select_third_n,
   input  wire logic                       burst_linear,
   input  wire logic                       output_enable_n,
   // data lanes
   input  wire logic [LANES*8-1:0]         dq_in,
   output var  logic [LANES*8-1:0]         dq_out,
   output logic                            dq_oe,
   input  wire logic [LANES-1:0]           parity_lane_in,
   output var  logic [LANES-1:0]           parity_lane_out,
   output logic                            parity_lane_oe,
   // status
   output var  logic                       write_queue_ready
);

   // ==========================================================
   // shape check
   initial
   begin
      if (!((LANES == 2 && ADDR_W == 22) || (LANES == 4 && ADDR_W == 21) ||
            (LANES == 8 && ADDR_W == 20) || ADDR_W < 20))
         $error("pss_sram: lanes and address width do not match an organisation");
      if (LANES != 2 && LANES != 4 && LANES != 8)
         $error("pss_sram: lanes must be 2, 4 or 8");
   end

   localparam int WW = LANES * PSS_LANE_W;
   localparam int QW = ADDR_W + LANES + WW;

   // ==========================================================
   // declarations
   logic [WW-1:0]          mem [2**ADDR_W];
   logic                   en;
   logic                   sel;
   pss_op_e                op_nxt;
   logic [ADDR_W-1:0]      addr_nxt;
   logic [1:0]             beat_nxt;
   logic [1:0]             low_nxt;
   pss_op_e                op_a_r;
   pss_op_e                op_b_r;
   pss_op_e                burst_op_r;
   logic [ADDR_W-1:0]      addr_a_r;
   logic [ADDR_W-1:0]      addr_b_r;
   logic [LANES-1:0]       mask_a_r;
   logic [LANES-1:0]       mask_b_r;
   logic [ADDR_W-3:0]      upper_r;
   logic [1:0]             base_r;
   logic [1:0]             beat_r;
   logic [WW-1:0]          rd_b_r;
   logic                   dq_oe_r;
   logic [WW-1:0]          wword;
   logic [WW-1:0]          rd_merge;
   logic                   push;
   logic                   q_in_ready;
   logic                   q_out_valid;
   logic [QW-1:0]          q_out_data;
   logic [ADDR_W-1:0]      q_addr;
   logic [LANES-1:0]       q_mask;
   logic [WW-1:0]          q_word;

   // apply a pending byte-masked write to a word read from the array
   function automatic logic [WW-1:0] pss_merge(
      input logic [WW-1:0]     word,
      input logic [ADDR_W-1:0] raddr,
      input logic              hit,
      input logic [ADDR_W-1:0] waddr,
      input logic [LANES-1:0]  mask,
      input logic [WW-1:0]     wdata);
      logic [WW-1:0] res;
      res = word;
      for (int i = 0; i < LANES; i++)
      begin
         if (hit && raddr == waddr && mask[i])
            res[i*PSS_LANE_W +: PSS_LANE_W] = wdata[i*PSS_LANE_W +: PSS_LANE_W];
      end
      return res;
   endfunction

   // ==========================================================
   // command decode and burst counter
   assign en  = !cycle_qualify_n;
   assign sel = !select_first_n && select_second && !select_third_n;

   always_comb
   begin
      beat_nxt = beat_r + PSS_BEAT_STEP;
      low_nxt  = burst_linear ? base_r + beat_nxt : base_r ^ beat_nxt;
      if (burst_advance_or_load)
      begin
         // a continue keeps the op of the burst; after a deselect it stays idle
         op_nxt   = burst_op_r;
         addr_nxt = {upper_r, low_nxt};
      end
      else
      begin
         if (!sel)
            op_nxt = PSS_OP_IDLE;
         else if (write_enable_n)
            op_nxt = PSS_OP_READ;
         else
            op_nxt = PSS_OP_WRITE;
         addr_nxt = addr;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         burst_op_r <= PSS_OP_IDLE;
         upper_r    <= '0;
         base_r     <= PSS_BEAT_FIRST;
         beat_r     <= PSS_BEAT_FIRST;
      end
      else if (en)
      begin
         if (burst_advance_or_load)
            beat_r <= beat_nxt;
         else
         begin
            burst_op_r <= op_nxt;
            upper_r    <= addr[ADDR_W-1:2];
            base_r     <= addr[1:0];
            beat_r     <= PSS_BEAT_FIRST;
         end
      end
   end

   // ==========================================================
   // input register and read stage
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         op_a_r   <= PSS_OP_IDLE;
         op_b_r   <= PSS_OP_IDLE;
         addr_a_r <= '0;
         addr_b_r <= '0;
         mask_a_r <= '0;
         mask_b_r <= '0;
      end
      else if (en)
      begin
         op_a_r   <= op_nxt;
         addr_a_r <= addr_nxt;
         mask_a_r <= ~lane_write_select_n;
         op_b_r   <= op_a_r;
         addr_b_r <= addr_a_r;
         mask_b_r <= mask_a_r;
      end
   end

   // the write queue drains every enabled cycle, so at most the head entry
   // and the one arriving now can be newer than the array: forward both
   always_comb
   begin
      rd_merge = pss_merge(mem[addr_a_r], addr_a_r, q_out_valid,
                           q_addr, q_mask, q_word);
      rd_merge = pss_merge(rd_merge, addr_a_r, push,
                           addr_b_r, mask_b_r, wword);
   end

   always_ff @(posedge sys_clk)
   begin
      if (en && op_a_r == PSS_OP_READ)
         rd_b_r <= rd_merge;
   end

   // ==========================================================
   // output register and driver control
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         dq_out          <= '0;
         parity_lane_out <= '0;
         dq_oe_r         <= 1'b0;
      end
      else if (en)
      begin
         dq_oe_r <= (op_b_r == PSS_OP_READ);
         if (op_b_r == PSS_OP_READ)
         begin
            for (int i = 0; i < LANES; i++)
            begin
               dq_out[i*8 +: 8]   <= rd_b_r[i*PSS_LANE_W +: 8];
               parity_lane_out[i] <= rd_b_r[i*PSS_LANE_W + 8];
            end
         end
      end
   end

   // the output enable pin acts without the clock
   assign dq_oe          = dq_oe_r && !output_enable_n;
   assign parity_lane_oe = dq_oe_r && !output_enable_n;

   // ==========================================================
   // write data capture and self-timed commit
   always_comb
   begin
      for (int i = 0; i < LANES; i++)
         wword[i*PSS_LANE_W +: PSS_LANE_W] = {parity_lane_in[i], dq_in[i*8 +: 8]};
   end

   assign push = en && op_b_r == PSS_OP_WRITE;

   pss_fifo
   #(
      .W     (QW),
      .DEPTH (PSS_FIFO_DEPTH)
   )
   u_wq
   (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_valid  (push),
      .in_ready  (q_in_ready),
      .in_data   ({addr_b_r, mask_b_r, wword}),
      .out_valid (q_out_valid),
      .out_ready (en),
      .out_data  (q_out_data)
   );

   assign {q_addr, q_mask, q_word} = q_out_data;

   always_ff @(posedge sys_clk)
   begin
      if (en && q_out_valid)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (q_mask[i])
               mem[q_addr][i*PSS_LANE_W +: PSS_LANE_W] <= q_word[i*PSS_LANE_W +: PSS_LANE_W];
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         write_queue_ready <= 1'b1;
      else
         write_queue_ready <= q_in_ready;
   end

   // ==========================================================
   // checks
   a_capture_inputs: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && !burst_advance_or_load && sel |=> addr_a_r == $past(addr))
      else $error("load address not captured");
   a_out_on_edge: assert property (@(posedge sys_clk) disable iff (!resetn)
      $past(resetn) && !$stable(dq_out) |->
         $past(en) && $past(op_b_r) == PSS_OP_READ)
      else $error("read data changed without an enabled read");
   a_suspend_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !en |=> $stable(op_a_r) && $stable(op_b_r) && $stable(dq_oe_r))
      else $error("pipeline moved while suspended");
   a_write_strobe: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && !burst_advance_or_load && write_enable_n |=> op_a_r != PSS_OP_WRITE)
      else $error("write without write strobe");
   a_write_drain: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && q_out_valid && !push |=> !q_out_valid)
      else $error("queued write did not complete");
   a_deselect_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && !burst_advance_or_load && !sel |=> op_a_r == PSS_OP_IDLE)
      else $error("unselected cycle not a deselect");
   a_write_float: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && op_b_r == PSS_OP_WRITE |=> !dq_oe && !parity_lane_oe)
      else $error("drivers on during write data phase");
   a_back_to_back: assert property (@(posedge sys_clk) disable iff (!resetn)
      en |=> op_b_r == $past(op_a_r))
      else $error("command not passed on next cycle");
   a_burst_order: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && burst_advance_or_load |=> addr_a_r[1:0] == ($past(burst_linear) ?
         2'($past(base_r) + $past(beat_r) + 2'h1) :
         2'($past(base_r) ^ 2'($past(beat_r) + 2'h1))))
      else $error("burst address order wrong");
   a_oe_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      output_enable_n |-> !dq_oe && !parity_lane_oe)
      else $error("drivers on with output enable high");
   a_read_latency: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && op_a_r == PSS_OP_READ ##1 en |=> dq_oe_r)
      else $error("read data not out two edges after command");
   a_beat_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
      en && burst_advance_or_load |=> beat_r == 2'($past(beat_r) + 2'h1))
      else $error("burst counter did not advance");

endmodule // pss_sram

`default_nettype wire

// ---- pss_ctrl_model.sv ----
// controller-side model: hands write data to the sram in its data phase
// assumes commands come from the bench on the same sys_clk
`timescale 1ns/100ps
`default_nettype none

module pss_ctrl_model
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // command seen on the bus
   input  wire logic        cycle_qualify_n,
   input  wire logic        burst_advance_or_load,
   input  wire logic        write_enable_n,
   input  wire logic [2:0]  sel,
   input  wire logic [35:0] wr_word,
   // data lanes toward the sram
   output logic [31:0]      dq_in,
   output logic [3:0]       parity_lane_in
);
   logic        burst_wr_r   = 1'b0;
   logic        stage_wr_r   = 1'b0;
   logic [35:0] stage_word_r = 36'h0;
   logic        data_wr_r    = 1'b0;
   logic [35:0] data_word_r  = 36'h0;
   logic [35:0] last_r       = 36'h0;
   logic        wr_now;
   logic [35:0] bus_word;

   // ======================================
   // write tracking
   // a continue keeps the op of its burst; a deselected burst stays idle
   assign wr_now = burst_advance_or_load ? burst_wr_r
                 : (sel == 3'h2) && !write_enable_n;

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         burst_wr_r <= 1'b0;
         stage_wr_r <= 1'b0;
         data_wr_r  <= 1'b0;
      end
      else if (!cycle_qualify_n)
      begin
         burst_wr_r   <= wr_now;
         stage_wr_r   <= wr_now;
         stage_word_r <= wr_word;
         // second stage: data stands up to the second enabled edge
         data_wr_r    <= stage_wr_r;
         data_word_r  <= stage_word_r;
      end
   end

   // ======================================
   // data lanes
   // released bus toggles each cycle so stale data never looks valid
   assign bus_word = data_wr_r ? data_word_r : ~last_r;
   assign {parity_lane_in, dq_in} = bus_word;

   always_ff @(posedge sys_clk)
   begin
      last_r <= bus_word;
   end
endmodule // pss_ctrl_model

`default_nettype wire

// ---- pss_sram_test.sv ----
// self-checking bench of the pipelined burst sram core
// assumes pss_pkg, pss_fifo, pss_sram and pss_ctrl_model compiled first
`timescale 1ns/100ps
`default_nettype none

module pss_sram_test
   import pss_pkg::*;
;
   typedef struct packed {
      logic        cqn;
      logic        adv;
      logic        we_n;
      logic [2:0]  sel;
      logic [3:0]  bw_n;
      logic [7:0]  addr;
      logic        rd;
      logic [35:0] word;
   } pss_row_s;

   logic        sys_clk;
   logic        resetn;
   logic        burst_linear;
   logic        oe_n;
   pss_row_s    cur;
   pss_row_s    q[$];
   logic [31:0] dq_in;
   logic [31:0] dq_out;
   logic        dq_oe;
   logic [3:0]  par_in;
   logic [3:0]  par_out;
   logic        par_oe;
   logic        wq_ready;
   logic [36:0] p1_r;
   logic [36:0] p2_r;
   logic [36:0] p3_r;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   // ======================================
   // row builders
   function automatic pss_row_s wr(logic [7:0] a, logic [3:0] m,
                                   logic [35:0] w);
      return '{1'b0, 1'b0, 1'b0, 3'h2, m, a, 1'b0, w};
   endfunction
   function automatic pss_row_s rd(logic [7:0] a, logic [35:0] w);
      return '{1'b0, 1'b0, 1'b1, 3'h2, 4'hf, a, 1'b1, w};
   endfunction
   // write-enable set opposite to the burst op to prove it is ignored
   function automatic pss_row_s ct(logic r, logic [3:0] m, logic [35:0] w);
      return '{1'b0, 1'b1, ~r, 3'h2, m, 8'hff, r, w};
   endfunction
   function automatic pss_row_s ds(logic [2:0] s);
      return '{1'b0, 1'b0, 1'b0, s, 4'h0, 8'h20, 1'b0, 36'h0_dead_beef};
   endfunction
   function automatic pss_row_s st();
      return '{1'b1, 1'b0, 1'b1, 3'h2, 4'h0, 8'h10, 1'b0, 36'h0};
   endfunction

   // ======================================
   // design and controller model
   pss_sram #(.ADDR_W(8), .LANES(4)) u_dut (
      .sys_clk(sys_clk), .resetn(resetn), .cycle_qualify_n(cur.cqn),
      .addr(cur.addr), .write_enable_n(cur.we_n),
      .burst_advance_or_load(cur.adv), .lane_write_select_n(cur.bw_n),
      .select_first_n(cur.sel[2]), .select_second(cur.sel[1]),
      .select_third_n(cur.sel[0]), .burst_linear(burst_linear),
      .output_enable_n(oe_n), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .parity_lane_in(par_in),
      .parity_lane_out(par_out), .parity_lane_oe(par_oe),
      .write_queue_ready(wq_ready));

   pss_ctrl_model u_ctrl (
      .sys_clk(sys_clk), .resetn(resetn), .cycle_qualify_n(cur.cqn),
      .burst_advance_or_load(cur.adv), .write_enable_n(cur.we_n),
      .sel(cur.sel), .wr_word(cur.word), .dq_in(dq_in),
      .parity_lane_in(par_in));

   // ======================================
   // clock, timeout, checking
   initial
   begin
      sys_clk = 1'b0;
      forever #(PSS_CLK_NS / 2) sys_clk = ~sys_clk;
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 500)
      begin
         n_fail++;
         stop_test;
      end
   end

   // expected read pipe: command edge loads p1, data stands after two more
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         p1_r <= '0;
         p2_r <= '0;
         p3_r <= '0;
      end
      else if (!cur.cqn)
      begin
         p1_r <= {cur.rd, cur.word};
         p2_r <= p1_r;
         p3_r <= p2_r;
      end
   end

   always @(negedge sys_clk)
   begin
      if (cycles > 17)
      begin
         chk(dq_oe === (p3_r[36] && !oe_n), "drive enable");
         chk(par_oe === dq_oe, "parity drive enable");
         if (p3_r[36])
            chk({par_out, dq_out} === p3_r[35:0], "read data");
      end
   end

   task automatic drive(input pss_row_s r);
      @(posedge sys_clk);
      #1;
      cur = r;
   endtask

   task automatic run_rows;
      foreach (q[i])
         drive(q[i]);
   endtask

   // ======================================
   // main sequence
   initial
   begin
      resetn = 1'b0;
      burst_linear = 1'b1;
      oe_n = 1'b0;
      cur = ds(3'h6);
      repeat (16) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      q = '{wr(8'h10, 4'h0, 36'h0_1010_1010),
            wr(8'h21, 4'h0, 36'h1_2121_2121), ct(1'b0, 4'h0, 36'h2_2222_2222),
            ct(1'b0, 4'h0, 36'h3_2323_2323), ct(1'b0, 4'h0, 36'h4_2020_2020),
            rd(8'h10, 36'h0_1010_1010), rd(8'h21, 36'h1_2121_2121),
            ct(1'b1, 4'hf, 36'h2_2222_2222), ct(1'b1, 4'hf, 36'h3_2323_2323),
            ct(1'b1, 4'hf, 36'h4_2020_2020), wr(8'h10, 4'ha, 36'h5_ffff_ffff),
            rd(8'h10, 36'h5_10ff_10ff), ds(3'h6), ds(3'h0), ds(3'h3),
            ct(1'b0, 4'h0, 36'h0_dead_beef), rd(8'h20, 36'h4_2020_2020),
            rd(8'h21, 36'h1_2121_2121), st(), st(), ds(3'h6), ds(3'h6)};
      run_rows;
      $display("linear rows done");
      chk(wq_ready === 1'b1, "write queue ready");
      burst_linear = 1'b0;
      q = '{rd(8'h22, 36'h2_2222_2222), ct(1'b1, 4'hf, 36'h3_2323_2323),
            ct(1'b1, 4'hf, 36'h4_2020_2020), ct(1'b1, 4'hf, 36'h1_2121_2121),
            ct(1'b1, 4'hf, 36'h2_2222_2222), ds(3'h6), ds(3'h6)};
      run_rows;
      $display("interleaved rows done");
      // output gate is combinational, so probe it inside one half cycle
      q = '{rd(8'h10, 36'h5_10ff_10ff), ds(3'h6), ds(3'h6)};
      run_rows;
      // read data stands after the edge that samples the last row
      @(posedge sys_clk);
      #2;
      oe_n = 1'b1;
      #1;
      chk(dq_oe === 1'b0, "gate off");
      oe_n = 1'b0;
      #1;
      chk(dq_oe === 1'b1, "gate on");
      $display("output gate test done");
      drive(rd(8'h10, 36'h5_10ff_10ff));
      @(posedge sys_clk);
      #1;
      resetn = 1'b0;
      @(posedge sys_clk);
      #1;
      chk(dq_oe === 1'b0, "reset drive");
      chk({par_out, dq_out} === 36'h0, "reset data");
      chk(wq_ready === 1'b1, "reset queue ready");
      resetn = 1'b1;
      q = '{rd(8'h10, 36'h5_10ff_10ff), ds(3'h6), ds(3'h6), ds(3'h6)};
      run_rows;
      // let the last read reach the negedge checker before the verdict
      repeat (2) @(posedge sys_clk);
      $display("reset test done");
      stop_test;
   end
endmodule // pss_sram_test

`default_nettype wire
